/* File: logic/sfp_pkg.sv */
// package: register offsets, field positions, reset values and the bits-per-byte count
package sfp_pkg;
    localparam logic [1:0] OFF_DATA    = 2'h1;
    localparam logic [1:0] OFF_CTRL    = 2'h2;
    localparam logic [1:0] OFF_STAT    = 2'h3;
    localparam int         BIT_IRQ_EN  = 7;
    localparam int         BIT_PORT_EN = 6;
    localparam int         BIT_RATE_H  = 5;
    localparam int         BIT_CTRL_SEL = 4;
    localparam int         BIT_CLOCK_POLARITY    = 3;
    localparam int         BIT_CLOCK_PHASE    = 2;
    localparam int         BIT_DONE    = 7;
    localparam int         BIT_WRITE_COLLISION_FLAG    = 6;
    localparam int         BIT_OVR     = 5;
    localparam int         BIT_MODE_FAULT_FLAG    = 4;
    localparam int         BIT_OUT_DIS = 2;
    localparam int         BIT_SEL_SRC = 1;
    localparam int         BIT_SW_SEL  = 0;
    localparam logic [7:0] CTRL_RESET  = 8'h00;
    localparam logic [7:0] STAT_RESET  = 8'h00;
    localparam logic [7:0] DATA_RESET  = 8'h00;
    localparam int         BITS_PER_BYTE = 8;
endpackage

/* File: logic/sfp_sync.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module sfp_sync #(
    parameter int  WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             reset_n_i,
    input  wire logic [WIDTH-1:0] d_i,
    input  wire logic [WIDTH-1:0] init_i,
    output logic      [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] stage1;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            stage1 <= '1;
            q_o    <= '1;
        end else begin
            stage1 <= d_i;
            q_o    <= stage1;
        end
    end
    logic unused_init;
    assign unused_init = |init_i;
endmodule
`default_nettype wire

/* File: logic/sfp_spi.sv */
// serial port core: controller/target shifter, error flags, sleep handling
// How it works
// - polarity and phase pick one of four timings and the capture edge.
// - select low in controller mode sets mode fault, interrupts if enabled.
// - mode fault clears port enable, releasing all serial outputs.
// - mode fault clears controller select, forcing target mode.
// - mode fault clears on status read while set, then control write.
// - while mode fault set and not yet seen in a status read, writes setting enable or controller are refused.
// - byte done while done flag set raises overrun and interrupt.
// - receive buffer keeps first byte after done cleared; later ones dropped.
// - status register read clears overrun.
// - data write during transfer is ignored and sets write collision.
// - write collision never raises an interrupt.
// - received bytes land in a buffer read synchronously.
// - in light sleep the port runs and events wake the processor.
// - in deep stop registers freeze; an allowed wake event resumes it.
// - target done wakes deep stop; fault and overrun do not.
// - deep-stop wake works with internal select low or high on entry.
// - done, fault and overrun share one interrupt, gated by enable and global mask.
// - control bits 7..0 as laid out; upper four reset to zero.
// - phase 0 captures on first edge, phase 1 on second.
// - done sets at byte end; clears on status access then data access.
// - software select mode uses the select level bit instead of pin.
//
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module sfp_spi (
    input  wire logic       CLK_I,
    input  wire logic       RESET_N_I,
    input  wire logic [1:0] ADDR_I,
    input  wire logic [7:0] WDATA_I,
    input  wire logic       WR_I,
    input  wire logic       RD_I,
    output logic      [7:0] RDATA_O,
    input  wire logic       SCK_I,
    output logic            SCK_O,
    output logic            SCK_OE_O,
    input  wire logic       MOSI_I,
    output logic            MOSI_O,
    output logic            MOSI_OE_O,
    input  wire logic       MISO_I,
    output logic            MISO_O,
    output logic            MISO_OE_O,
    input  wire logic       SEL_N_I,
    input  wire logic       GLOBAL_MASK_I,
    input  wire logic       DEEP_STOP_I,
    output logic            IRQ_O,
    output logic            WAKE_O
);
    typedef enum logic [2:0] {
        SFP_IDLE  = 3'b001,
        SFP_SHIFT = 3'b010,
        SFP_DONE  = 3'b100
    } sfp_state_e;

    logic [7:0] ctrl;
    logic [7:0] stat;
    logic [7:0] shifter;
    logic [7:0] rx_buf;
    logic [3:0] edge_cnt;
    logic [6:0] div_cnt;
    logic       mode_fault_flag_armed;
    logic       done_armed;
    logic       sck_int;
    logic       halted;
    sfp_state_e state;
    logic [3:0] pins_s;
    logic       sck_prev;
    logic       sel_int;
    logic       busy;
    logic       sck_rise;
    logic       sck_fall;
    logic       lead_edge;
    logic       cap_edge;
    logic       master;
    logic       tick;
    logic       byte_end;
    logic       data_wr;
    logic       data_rd;
    logic       stat_rd;
    logic       ctrl_wr;
    logic       mode_fault_flag_set;
    logic [6:0] div_max;
    logic       cap_bit;
    logic       stat_access;

    sfp_sync #(
        .WIDTH (4)
    ) u_sync (
        .clk_i     (CLK_I),
        .reset_n_i (RESET_N_I),
        .d_i       ({SCK_I, SEL_N_I, MISO_I, MOSI_I}),
        .init_i    (4'hF),
        .q_o       (pins_s)
    );

    assign master      = ctrl[sfp_pkg::BIT_CTRL_SEL];
    assign sel_int     = stat[sfp_pkg::BIT_SEL_SRC] ? stat[sfp_pkg::BIT_SW_SEL] : pins_s[2];
    assign busy        = (state == SFP_SHIFT);
    assign data_wr     = WR_I && ADDR_I == sfp_pkg::OFF_DATA && !halted;
    assign data_rd     = RD_I && ADDR_I == sfp_pkg::OFF_DATA && !halted;
    assign stat_rd     = RD_I && ADDR_I == sfp_pkg::OFF_STAT && !halted;
    assign stat_access = (RD_I || WR_I) && ADDR_I == sfp_pkg::OFF_STAT && !halted;
    assign ctrl_wr     = WR_I && ADDR_I == sfp_pkg::OFF_CTRL && !halted;
    // controller with select low is a fault
    assign mode_fault_flag_set    = master && ctrl[sfp_pkg::BIT_PORT_EN] && !sel_int && !halted;

    // rate: rate_bit_high=1 removes the divide-by-2 for rate selects 00 and 10 only
    always_comb begin
        case ({ctrl[1], ctrl[0]})
            2'b00:   div_max = ctrl[sfp_pkg::BIT_RATE_H] ? 7'h01 : 7'h03;
            2'b01:   div_max = 7'h07;
            2'b10:   div_max = ctrl[sfp_pkg::BIT_RATE_H] ? 7'h0F : 7'h1F;
            default: div_max = 7'h3F;
        endcase
    end

    // edge detection on the internal or sampled clock
    assign sck_rise  = master ? (tick && !sck_int) : (pins_s[3] && !sck_prev);
    assign sck_fall  = master ? (tick && sck_int) : (!pins_s[3] && sck_prev);
    assign lead_edge = ctrl[sfp_pkg::BIT_CLOCK_POLARITY] ? sck_fall : sck_rise;
    // phase 0 captures on leading edge, phase 1 on trailing edge
    assign cap_edge  = ctrl[sfp_pkg::BIT_CLOCK_PHASE] ? (sck_rise || sck_fall) && !lead_edge : lead_edge;
    assign cap_bit   = master ? pins_s[1] : pins_s[0];
    assign tick      = master && busy && div_cnt == div_max;
    // last capture is edge 14 for phase 0 and edge 15 for phase 1
    assign byte_end  = busy && cap_edge && edge_cnt == 4'(2 * sfp_pkg::BITS_PER_BYTE - 2 + ctrl[sfp_pkg::BIT_CLOCK_PHASE]);

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            sck_prev <= 1'b1;
        end else begin
            sck_prev <= pins_s[3];
        end
    end

    // deep stop freezes registers; enters only on clock edge
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            halted <= 1'b0;
        end else begin
            halted <= DEEP_STOP_I && !WAKE_O;
        end
    end

    // control register
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            ctrl <= sfp_pkg::CTRL_RESET;
        end else if (mode_fault_flag_set) begin
            ctrl[sfp_pkg::BIT_PORT_EN]  <= 1'b0;
            ctrl[sfp_pkg::BIT_CTRL_SEL] <= 1'b0;
        end else if (ctrl_wr) begin
            ctrl <= WDATA_I;
            if (stat[sfp_pkg::BIT_MODE_FAULT_FLAG] && !mode_fault_flag_armed) begin
                ctrl[sfp_pkg::BIT_PORT_EN]  <= 1'b0;
                ctrl[sfp_pkg::BIT_CTRL_SEL] <= 1'b0;
            end
        end
    end

    // status register; set wins over clear
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            stat       <= sfp_pkg::STAT_RESET;
            mode_fault_flag_armed <= 1'b0;
            done_armed <= 1'b0;
        end else if (!halted || byte_end) begin
            if (stat_rd && stat[sfp_pkg::BIT_MODE_FAULT_FLAG]) begin
                mode_fault_flag_armed <= 1'b1;
            end else if (ctrl_wr) begin
                mode_fault_flag_armed <= 1'b0;
            end
            if (mode_fault_flag_set) begin
                stat[sfp_pkg::BIT_MODE_FAULT_FLAG] <= 1'b1;
            end else if (ctrl_wr && mode_fault_flag_armed) begin
                stat[sfp_pkg::BIT_MODE_FAULT_FLAG] <= 1'b0;
            end
            if (stat_access && stat[sfp_pkg::BIT_DONE]) begin
                done_armed <= 1'b1;
            end else if (data_rd || data_wr) begin
                done_armed <= 1'b0;
            end
            if (byte_end) begin
                stat[sfp_pkg::BIT_DONE] <= 1'b1;
            end else if ((data_rd || data_wr) && done_armed) begin
                stat[sfp_pkg::BIT_DONE] <= 1'b0;
            end
            if (byte_end && stat[sfp_pkg::BIT_DONE]) begin
                stat[sfp_pkg::BIT_OVR] <= 1'b1;
            end else if (stat_rd) begin
                stat[sfp_pkg::BIT_OVR] <= 1'b0;
            end
            if (data_wr && (busy || (stat[sfp_pkg::BIT_DONE] && !done_armed))) begin
                stat[sfp_pkg::BIT_WRITE_COLLISION_FLAG] <= 1'b1;
            end else if ((data_rd || data_wr) && stat_access == 1'b0 && done_armed) begin
                stat[sfp_pkg::BIT_WRITE_COLLISION_FLAG] <= 1'b0;
            end
            if (WR_I && ADDR_I == sfp_pkg::OFF_STAT && !halted) begin
                stat[2:0] <= WDATA_I[2:0];
            end
            stat[3] <= 1'b0;
        end
    end

    // shift engine; byte_end may run in deep stop to allow target wake
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            state    <= SFP_IDLE;
            shifter  <= sfp_pkg::DATA_RESET;
            edge_cnt <= 4'h0;
            div_cnt  <= 7'h00;
            sck_int  <= 1'b0;
        end else if (!ctrl[sfp_pkg::BIT_PORT_EN]) begin
            state   <= SFP_IDLE;
            sck_int <= ctrl[sfp_pkg::BIT_CLOCK_POLARITY];
        end else begin
            case (state)
                SFP_IDLE: begin
                    sck_int  <= ctrl[sfp_pkg::BIT_CLOCK_POLARITY];
                    edge_cnt <= 4'h0;
                    div_cnt  <= 7'h00;
                    if (data_wr && !(stat[sfp_pkg::BIT_DONE] && !done_armed)) begin
                        shifter <= WDATA_I;
                        state   <= master ? SFP_SHIFT : SFP_IDLE;
                    end
                    if (!master && !sel_int) begin
                        state <= SFP_SHIFT;
                    end
                end
                SFP_SHIFT: begin
                    div_cnt <= tick ? 7'h00 : 7'(div_cnt + 7'h01);
                    if (tick) begin
                        sck_int <= !sck_int;
                    end
                    if (sck_rise || sck_fall) begin
                        edge_cnt <= 4'(edge_cnt + 4'h1);
                    end
                    if (cap_edge) begin
                        shifter <= {shifter[6:0], cap_bit};
                    end
                    // frame ends on the sixteenth edge so a trailing edge is never counted twice
                    if ((sck_rise || sck_fall) && edge_cnt == 4'(2 * sfp_pkg::BITS_PER_BYTE - 1)) begin
                        state <= SFP_DONE;
                    end
                    if (!master && sel_int) begin
                        state <= SFP_IDLE;
                    end
                end
                SFP_DONE: begin
                    sck_int <= ctrl[sfp_pkg::BIT_CLOCK_POLARITY];
                    state   <= (!master && !sel_int && ctrl[sfp_pkg::BIT_CLOCK_PHASE]) ? SFP_SHIFT : SFP_IDLE;
                    edge_cnt <= 4'h0;
                end
                default: begin
                    state <= SFP_IDLE;
                end
            endcase
        end
    end

    // receive buffer holds first byte since done was cleared
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            rx_buf <= sfp_pkg::DATA_RESET;
        end else if (byte_end && !stat[sfp_pkg::BIT_DONE]) begin
            rx_buf <= {shifter[6:0], cap_bit};
        end
    end

    // read data, one cycle after the strobe
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            RDATA_O <= 8'h00;
        end else if (RD_I) begin
            case (ADDR_I)
                sfp_pkg::OFF_DATA: RDATA_O <= rx_buf;
                sfp_pkg::OFF_CTRL: RDATA_O <= ctrl;
                sfp_pkg::OFF_STAT: RDATA_O <= stat;
                default:           RDATA_O <= 8'h00;
            endcase
        end else begin
            RDATA_O <= 8'h00;
        end
    end

    // pins: outputs enabled only with port enable
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            SCK_O     <= 1'b0;
            SCK_OE_O  <= 1'b0;
            MOSI_O    <= 1'b0;
            MOSI_OE_O <= 1'b0;
            MISO_O    <= 1'b0;
            MISO_OE_O <= 1'b0;
        end else begin
            SCK_O     <= sck_int;
            SCK_OE_O  <= ctrl[sfp_pkg::BIT_PORT_EN] && master && !mode_fault_flag_set;
            MOSI_O    <= shifter[7];
            MOSI_OE_O <= ctrl[sfp_pkg::BIT_PORT_EN] && master && !mode_fault_flag_set && !stat[sfp_pkg::BIT_OUT_DIS];
            MISO_O    <= shifter[7];
            MISO_OE_O <= ctrl[sfp_pkg::BIT_PORT_EN] && !master && !sel_int && !stat[sfp_pkg::BIT_OUT_DIS];
        end
    end

    // one shared interrupt; write collision excluded; wake only on target done
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            IRQ_O  <= 1'b0;
            WAKE_O <= 1'b0;
        end else begin
            IRQ_O  <= ctrl[sfp_pkg::BIT_IRQ_EN] && !GLOBAL_MASK_I
                      && (stat[sfp_pkg::BIT_DONE] || stat[sfp_pkg::BIT_MODE_FAULT_FLAG] || stat[sfp_pkg::BIT_OVR]);
            WAKE_O <= halted && !master && ctrl[sfp_pkg::BIT_IRQ_EN] && byte_end;
        end
    end

    AST_MODE_FAULT_FLAG_DROPS_EN: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
        mode_fault_flag_set |=> !ctrl[sfp_pkg::BIT_PORT_EN] && !ctrl[sfp_pkg::BIT_CTRL_SEL] && stat[sfp_pkg::BIT_MODE_FAULT_FLAG])
        else $error("mode fault did not clear enables");
    AST_OVR_ON_DONE: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
        byte_end && stat[sfp_pkg::BIT_DONE] && !halted |=> stat[sfp_pkg::BIT_OVR])
        else $error("overrun not flagged");
    AST_BUF_KEPT: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
        stat[sfp_pkg::BIT_DONE] |=> $stable(rx_buf))
        else $error("buffer overwritten");
    AST_WRITE_COLLISION_FLAG: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
        data_wr && busy |=> stat[sfp_pkg::BIT_WRITE_COLLISION_FLAG] && ($stable(shifter) || $past(cap_edge)))
        else $error("collision not flagged");
    AST_IRQ_GATE: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
        !ctrl[sfp_pkg::BIT_IRQ_EN] ##1 !ctrl[sfp_pkg::BIT_IRQ_EN] |-> !IRQ_O)
        else $error("irq without enable");
    AST_OVR_CLR: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
        stat_rd && !byte_end |=> !stat[sfp_pkg::BIT_OVR])
        else $error("overrun not cleared");
    AST_MODE_FAULT_FLAG_HOLD: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
        stat[sfp_pkg::BIT_MODE_FAULT_FLAG] && !mode_fault_flag_armed |=> stat[sfp_pkg::BIT_MODE_FAULT_FLAG])
        else $error("mode fault cleared early");
    AST_OE_OFF: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
        !ctrl[sfp_pkg::BIT_PORT_EN] |=> !SCK_OE_O && !MOSI_OE_O && !MISO_OE_O)
        else $error("outputs driven while disabled");
    COV_BYTE: cover property (@(posedge CLK_I) byte_end);
    COV_OVR: cover property (@(posedge CLK_I) stat[sfp_pkg::BIT_OVR]);
    COV_MODE_FAULT_FLAG: cover property (@(posedge CLK_I) mode_fault_flag_set);
endmodule
`default_nettype wire

/* File: verification/sfp_far.sv */
// far-side serial controller model: drives clock, data and select toward the block
`timescale 1ns/1ns
`default_nettype none
module sfp_far (
    input  wire logic clk_i,
    input  wire logic pol_i,
    input  wire logic pha_i,
    input  wire logic miso_i,
    output logic      sck_o,
    output logic      mosi_o,
    output logic      sel_n_o
);
    localparam int HALF = 8; // 80 ns half period at 100 MHz
    logic busy = 1'b0;
    initial begin
        sck_o   = 1'b0;
        mosi_o  = 1'b0;
        sel_n_o = 1'b1;
    end
    // clock rests at the selected polarity outside frames
    always @(pol_i) if (!busy) sck_o <= pol_i;
    task automatic set_sel(input logic lvl);
        sel_n_o <= lvl;
        @(posedge clk_i);
    endtask
    // one byte, msb first; hold keeps the select low afterwards
    task automatic xfer(input logic [7:0] tx, input logic hold, output logic [7:0] rx);
        busy = 1'b1;
        sel_n_o <= 1'b0;
        repeat (HALF) @(posedge clk_i);
        for (int i = 7; i >= 0; i--) begin
            if (!pha_i) mosi_o <= tx[i];
            repeat (HALF) @(posedge clk_i);
            sck_o <= ~pol_i;
            if (pha_i) mosi_o <= tx[i]; else rx[i] = miso_i;
            repeat (HALF) @(posedge clk_i);
            sck_o <= pol_i;
            if (pha_i) rx[i] = miso_i;
        end
        repeat (HALF) @(posedge clk_i);
        mosi_o  <= ~mosi_o;
        sel_n_o <= ~hold;
        busy = 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: verification/sfp_spi_tb.sv */
// self-checking bench for the serial port fault, sleep and interrupt block
`timescale 1ns/1ns
`default_nettype none
module sfp_spi_tb;
    localparam logic [1:0] A_DATA = sfp_pkg::OFF_DATA;
    localparam logic [1:0] A_CTRL = sfp_pkg::OFF_CTRL;
    localparam logic [1:0] A_STAT = sfp_pkg::OFF_STAT;
    logic       CLK_I = 1'b0;
    logic       RESET_N_I = 1'b0;
    logic [1:0] ADDR_I = 2'h0;
    logic [7:0] WDATA_I = 8'h00;
    logic       WR_I = 1'b0;
    logic       RD_I = 1'b0;
    logic       GLOBAL_MASK_I = 1'b0;
    logic       DEEP_STOP_I = 1'b0;
    logic [7:0] RDATA_O;
    logic       SCK_O, SCK_OE_O, MOSI_O, MOSI_OE_O, MISO_O, MISO_OE_O, IRQ_O, WAKE_O;
    logic       far_sck, far_mosi, far_sel_n;
    logic       clk_pol = 1'b0;
    logic       clk_pha = 1'b0;
    logic       tgl = 1'b0;
    logic       saw_wake = 1'b0;
    logic [7:0] rx;
    int         n_errors = 0;
    int         n_tests = 0;
    wire logic  sck_w  = SCK_OE_O ? SCK_O : far_sck;
    wire logic  mosi_w = MOSI_OE_O ? MOSI_O : far_mosi;
    wire logic  miso_w = MISO_OE_O ? MISO_O : tgl; // released line shows a changing pattern
    always #5 CLK_I = ~CLK_I;
    always @(posedge CLK_I) tgl <= ~tgl;
    always @(posedge CLK_I) if (WAKE_O === 1'b1) saw_wake <= 1'b1;
    sfp_spi uut (
        .CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
        .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .SCK_I(sck_w), .SCK_O(SCK_O),
        .SCK_OE_O(SCK_OE_O), .MOSI_I(mosi_w), .MOSI_O(MOSI_O), .MOSI_OE_O(MOSI_OE_O),
        .MISO_I(miso_w), .MISO_O(MISO_O), .MISO_OE_O(MISO_OE_O), .SEL_N_I(far_sel_n),
        .GLOBAL_MASK_I(GLOBAL_MASK_I), .DEEP_STOP_I(DEEP_STOP_I), .IRQ_O(IRQ_O), .WAKE_O(WAKE_O)
    );
    sfp_far far (
        .clk_i(CLK_I), .pol_i(clk_pol), .pha_i(clk_pha), .miso_i(miso_w),
        .sck_o(far_sck), .mosi_o(far_mosi), .sel_n_o(far_sel_n)
    );
    task automatic summarize();
        if (n_errors == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        ADDR_I  <= a;
        WDATA_I <= d;
        WR_I    <= 1'b1;
        @(posedge CLK_I);
        WR_I    <= 1'b0;
        @(posedge CLK_I);
    endtask
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        ADDR_I <= a;
        RD_I   <= 1'b1;
        @(posedge CLK_I);
        RD_I   <= 1'b0;
        @(negedge CLK_I);
        d = RDATA_O;
        @(posedge CLK_I);
    endtask
    task automatic rchk(input string nm, input logic [1:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk(nm, exp, d);
    endtask
    // status access, data read, then status again must be clean
    task automatic drain(input string nm, input logic [7:0] st, input logic [7:0] dt);
        rchk(nm, A_STAT, st);
        rchk(nm, A_DATA, dt);
        rchk(nm, A_STAT, 8'h00);
    endtask
    task automatic cfg(input logic [7:0] c);
        wr(A_CTRL, 8'h00);
        clk_pol <= c[sfp_pkg::BIT_CLOCK_POLARITY];
        clk_pha <= c[sfp_pkg::BIT_CLOCK_PHASE];
        @(posedge CLK_I);
        wr(A_CTRL, c);
    endtask
    task automatic t_reset();
        logic [7:0] d;
        rd(A_CTRL, d);
        chk("ctrl_reset_upper", 8'h00, d & 8'hF0);
        rchk("stat_reset", A_STAT, 8'h00);
        rchk("unmapped", 2'h0, 8'h00);
        chk("pin_enables", 8'h00, {5'h00, SCK_OE_O, MOSI_OE_O, MISO_OE_O});
        wr(A_CTRL, 8'h2F);
        rchk("ctrl_layout", A_CTRL, 8'h2F);
        wr(A_CTRL, 8'h00);
    endtask
    task automatic t_modes();
        for (int m = 0; m < 4; m++) begin
            cfg({4'h4, m[1:0], 2'h0});
            wr(A_DATA, 8'hA5 ^ 8'(m));
            far.xfer(8'h3C + 8'(m), 1'b0, rx);
            repeat (4) @(posedge CLK_I);
            chk("far_rx", 8'hA5 ^ 8'(m), rx);
            drain("mode_xfer", 8'h80, 8'h3C + 8'(m));
        end
    endtask
    task automatic t_overrun();
        GLOBAL_MASK_I <= 1'b1;
        cfg(8'hC0);
        far.xfer(8'h11, 1'b0, rx);
        repeat (4) @(posedge CLK_I);
        chk("irq_masked", 8'h00, {7'h00, IRQ_O});
        GLOBAL_MASK_I <= 1'b0;
        repeat (3) @(posedge CLK_I);
        chk("irq_done", 8'h01, {7'h00, IRQ_O});
        far.xfer(8'h22, 1'b0, rx);
        repeat (4) @(posedge CLK_I);
        drain("overrun", 8'hA0, 8'h11);
        chk("irq_cleared", 8'h00, {7'h00, IRQ_O});
    endtask
    task automatic t_collide();
        cfg(8'hC0);
        wr(A_DATA, 8'h5A);
        fork
            far.xfer(8'h77, 1'b0, rx);
            begin
                repeat (60) @(posedge CLK_I);
                wr(A_DATA, 8'hFF);
                repeat (3) @(posedge CLK_I);
                chk("irq_collide", 8'h00, {7'h00, IRQ_O});
            end
        join
        repeat (4) @(posedge CLK_I);
        chk("far_rx_collide", 8'h5A, rx);
        drain("collide", 8'hC0, 8'h77);
    endtask
    task automatic t_fault();
        cfg(8'hD0);
        far.set_sel(1'b0);
        repeat (6) @(posedge CLK_I);
        far.set_sel(1'b1);
        repeat (2) @(posedge CLK_I);
        rchk("fault_ctrl", A_CTRL, 8'h80);
        chk("fault_irq", 8'h01, {7'h00, IRQ_O});
        chk("fault_pins", 8'h00, {5'h00, SCK_OE_O, MOSI_OE_O, MISO_OE_O});
        wr(A_CTRL, 8'hD0);
        rchk("fault_refuse", A_CTRL, 8'h80);
        rchk("fault_stat", A_STAT, 8'h10);
        wr(A_CTRL, 8'hD0);
        rchk("fault_clear", A_STAT, 8'h00);
        rchk("fault_restore", A_CTRL, 8'hD0);
        chk("ctrl_pins", 8'h06, {4'h0, SCK_O, SCK_OE_O, MOSI_OE_O, MISO_OE_O});
        wr(A_CTRL, 8'h00);
    endtask
    task automatic t_deep();
        cfg(8'hC0);
        far.set_sel(1'b0);
        saw_wake = 1'b0;
        DEEP_STOP_I <= 1'b1;
        repeat (4) @(posedge CLK_I);
        wr(A_CTRL, 8'h00);
        far.xfer(8'h96, 1'b1, rx);
        repeat (4) @(posedge CLK_I);
        chk("wake", 8'h01, {7'h00, saw_wake});
        DEEP_STOP_I <= 1'b0;
        @(posedge CLK_I);
        rchk("frozen_ctrl", A_CTRL, 8'hC0);
        drain("deep", 8'h80, 8'h96);
        far.xfer(8'h00, 1'b0, rx);
        repeat (4) @(posedge CLK_I);
        drain("after_wake", 8'h80, 8'h00);
    endtask
    // nine byte frames of about 150 cycles plus register traffic fit well inside this span
    initial begin
        repeat (20000) @(posedge CLK_I);
        n_errors++;
        summarize();
    end
    initial begin
        repeat (2) @(posedge CLK_I);
        RESET_N_I <= 1'b1;
        @(posedge CLK_I);
        t_reset();
        t_modes();
        t_overrun();
        t_collide();
        t_fault();
        t_deep();
        summarize();
    end
endmodule
`default_nettype wire
